// ---- src/ckoc_top.sv ----
// Clock output routing, enables, stepping and general pin control
`timescale 1ns/1ps
module ckoc_top
    import ckoc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Stored settings loaded at power-up
    input wire logic i_nvm_load,
    input wire logic [2*NUM_OUT-1:0] i_nvm_route,
    input wire logic [DELAY_W*NUM_OUT-1:0] i_nvm_delay,
    // Source clocks for the crosspoint
    input wire logic i_loop_clk,
    input wire logic i_ref_clk,
    input wire logic i_frac_a_clk,
    input wire logic i_frac_b_clk,
    // Divider settings
    input wire logic [DIV_W*NUM_OUT-1:0] i_int_div,
    input wire logic [DIV_W*NUM_OUT-1:0] i_final_div,
    input wire logic [DIV_W-1:0] i_frac_a_val,
    input wire logic i_frac_a_is_frac,
    input wire logic [DIV_W-1:0] i_frac_b_val,
    input wire logic i_frac_b_is_frac,
    // Output control
    input wire logic [2*NUM_OUT-1:0] i_dis_mode,
    input wire logic [NUM_OUT-1:0] i_slow_out,
    input wire logic [NUM_OUT-1:0] i_api_en0,
    input wire logic [NUM_OUT-1:0] i_api_en1,
    input wire logic [NUM_OUT-1:0] i_grp0_map,
    input wire logic [NUM_OUT-1:0] i_grp1_map,
    input wire logic i_fine_skew,
    input wire logic i_run,
    // Host commands (single-cycle pulses)
    input wire logic i_cmd_ref_sel,
    input wire logic i_cmd_ref_val,
    input wire logic i_cmd_phase_adv,
    input wire logic i_cmd_phase_ret,
    input wire logic i_cmd_freq_up,
    input wire logic i_cmd_freq_dn,
    input wire logic i_cmd_fb_up,
    input wire logic i_cmd_fb_dn,
    input wire logic [FREQ_W-1:0] i_step_word,
    // Status sources
    input wire logic i_loop_lock_lost,
    input wire logic i_xtal_lost,
    input wire logic i_osc_in_lost,
    input wire logic [1:0] i_irq_mask,
    input wire logic i_irq_and_mode,
    input wire logic [1:0] i_sticky_clr,
    // General pins
    input wire logic [3*NUM_GPIO-1:0] i_gpio_fn,
    input wire logic [NUM_GPIO-1:0] i_gpio_low,
    input wire logic [NUM_GPIO-1:0] i_gpio_in,
    input wire logic [NUM_GPIO-1:0] i_gpio_driven,
    input wire logic i_serial_out,
    // Clock pads
    output logic [NUM_OUT-1:0] o_clk_pad,
    output logic [NUM_OUT-1:0] o_clk_pad_oe,
    output logic [NUM_OUT-1:0] o_clk_weak,
    // General pin drive
    output logic [NUM_GPIO-1:0] o_gpio_out,
    output logic [NUM_GPIO-1:0] o_gpio_oe,
    output logic [NUM_REUSE-1:0] o_reuse_out,
    // Status and settings
    output logic o_reference_loss,
    output logic o_interrupt_request_out,
    output logic o_ref_sel,
    output logic [FREQ_W-1:0] o_freq_offset,
    output logic [FREQ_W-1:0] o_fb_offset,
    output logic [PHASE_W-1:0] o_phase,
    output logic [2*NUM_OUT-1:0] o_route,
    output logic [DELAY_W*NUM_OUT-1:0] o_delay,
    output logic [DIV_W*NUM_OUT-1:0] o_final_div_eff,
    output logic [2*DIV_W+1:0] o_frac_cfg,
    output logic [1:0] o_sticky
);
    // Gather functions from general pins with polarity and defaults
    function automatic logic fn_seen(input logic [3*NUM_GPIO-1:0] fns, input logic [2:0] f,
                                     input logic [NUM_GPIO-1:0] lvl, input logic dflt);
        logic hit;
        logic val;
        hit = 1'b0;
        val = 1'b0;
        for (int i = 0; i < NUM_GPIO; i++) begin
            if (fns[3*i +: 3] == f) begin
                hit = 1'b1;
                val = val | lvl[i];
            end
        end
        return hit ? val : dflt;
    endfunction

    logic [NUM_GPIO-1:0] pin_lvl;
    logic [NUM_GPIO-1:0] pin_rise;
    logic [NUM_GPIO-1:0] pin_act;
    logic [NUM_GPIO-1:0] up_rise_v;
    logic [NUM_GPIO-1:0] dn_rise_v;
    logic en0_pin;
    logic en1_pin;
    logic pin_up;
    logic pin_dn;
    logic ref_loss_d;
    logic [1:0] sticky_q;
    logic [1:0] sticky_d;
    logic [1:0] sticky_m;
    logic irq_d;
    logic ref_sel_q;
    logic [FREQ_W-1:0] freq_q;
    logic [FREQ_W-1:0] fb_q;
    logic [PHASE_W-1:0] phase_q;
    logic [PHASE_W-1:0] phase_step;
    logic up_req;
    logic dn_req;
    ckoc_state_t st_q;
    ckoc_state_t st_d;
    logic [2*NUM_OUT-1:0] route_q;
    logic [DELAY_W*NUM_OUT-1:0] delay_q;
    logic [NUM_OUT-1:0] src_clk;
    logic [NUM_OUT-1:0] pad_w;
    logic [NUM_OUT-1:0] oe_w;
    logic [NUM_OUT-1:0] weak_w;
    logic [NUM_GPIO-1:0] gpo_d;
    logic [NUM_GPIO-1:0] gpo_oe_d;

    // Pin synchronisers; undriven pins fall back to their function default
    genvar g;
    generate
        for (g = 0; g < NUM_GPIO; g++) begin : g_pin
            logic dflt;
            ckoc_sync u_sync (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_pin(i_gpio_in[g] ^ i_gpio_low[g]),
                .o_level(pin_lvl[g]),
                .o_rise(pin_rise[g])
            );
            assign dflt = (i_gpio_fn[3*g +: 3] == CKOC_FN_EN0) |
                          (i_gpio_fn[3*g +: 3] == CKOC_FN_EN1);
            assign pin_act[g] = i_gpio_driven[g] ? pin_lvl[g] : dflt;
            assign up_rise_v[g] = pin_rise[g] & (i_gpio_fn[3*g +: 3] == CKOC_FN_STEP_UP);
            assign dn_rise_v[g] = pin_rise[g] & (i_gpio_fn[3*g +: 3] == CKOC_FN_STEP_DN);
        end
    endgenerate

    // Pin functions collected; enables default to asserted when unassigned
    assign en0_pin = fn_seen(i_gpio_fn, CKOC_FN_EN0, pin_act, 1'b1);
    assign en1_pin = fn_seen(i_gpio_fn, CKOC_FN_EN1, pin_act, 1'b1);
    assign pin_up = |up_rise_v;
    assign pin_dn = |dn_rise_v;

    // Status: reference loss from either source, sticky copies, interrupt combine
    assign ref_loss_d = i_xtal_lost | i_osc_in_lost;
    assign sticky_d = (sticky_q & ~i_sticky_clr) | {ref_loss_d, i_loop_lock_lost};
    assign sticky_m = sticky_q & i_irq_mask;
    // AND mode needs every enabled sticky; OR mode any one
    assign irq_d = i_irq_and_mode ? ((sticky_m == i_irq_mask) & (|i_irq_mask))
                                  : (|sticky_m);

    // Step requests; pins only reach the oscillator, and only while locked
    assign up_req = (i_cmd_freq_up | pin_up) & ~i_loop_lock_lost;
    assign dn_req = (i_cmd_freq_dn | pin_dn) & ~i_loop_lock_lost;
    assign phase_step = i_fine_skew ? 16'h0001 : 16'h0004;

    // Stepper state machine: one step per request
    always_comb begin
        st_d = CKOC_ST_IDLE;
        case (st_q)
            CKOC_ST_IDLE: begin
                if (up_req && !dn_req) st_d = CKOC_ST_UP;
                else if (dn_req && !up_req) st_d = CKOC_ST_DOWN;
                else st_d = CKOC_ST_IDLE;
            end
            CKOC_ST_UP: st_d = CKOC_ST_HOLD;
            CKOC_ST_DOWN: st_d = CKOC_ST_HOLD;
            CKOC_ST_HOLD: st_d = CKOC_ST_IDLE;
            default: st_d = CKOC_ST_IDLE;
        endcase
    end

    // Frequency, feedback and phase accumulators; ref select on command only
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q <= CKOC_ST_IDLE;
            freq_q <= FREQ_RST;
            fb_q <= FREQ_RST;
            phase_q <= PHASE_RST;
            ref_sel_q <= 1'b0;
            sticky_q <= CMD_RST;
        end else begin
            st_q <= st_d;
            if (st_q == CKOC_ST_UP) freq_q <= freq_q + i_step_word;
            else if (st_q == CKOC_ST_DOWN) freq_q <= freq_q - i_step_word;
            if (i_cmd_fb_up && !i_loop_lock_lost) fb_q <= fb_q + i_step_word;
            else if (i_cmd_fb_dn && !i_loop_lock_lost) fb_q <= fb_q - i_step_word;
            if (i_cmd_phase_adv && !i_cmd_phase_ret) phase_q <= phase_q + phase_step;
            else if (i_cmd_phase_ret && !i_cmd_phase_adv) phase_q <= phase_q - phase_step;
            if (i_cmd_ref_sel) ref_sel_q <= i_cmd_ref_val;
            sticky_q <= sticky_d;
        end
    end

    // Routing and delays captured from storage on load strobe
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            route_q <= '0;
            delay_q <= '0;
        end else if (i_nvm_load) begin
            route_q <= i_nvm_route;
            delay_q <= i_nvm_delay;
        end
    end

    // Crosspoint and output lanes
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_out
            ckoc_src_t src;
            logic frac_fed;
            assign src = ckoc_src_t'(route_q[2*g +: 2]);
            assign frac_fed = (src == CKOC_SRC_FRAC_A) | (src == CKOC_SRC_FRAC_B);
            assign src_clk[g] = (src == CKOC_SRC_LOOP) ? i_loop_clk :
                                (src == CKOC_SRC_REF) ? i_ref_clk :
                                (src == CKOC_SRC_FRAC_A) ? i_frac_a_clk : i_frac_b_clk;
            // Final divider only for fractional-fed lanes; integer path bypasses it
            always_ff @(posedge i_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    o_final_div_eff[DIV_W*g +: DIV_W] <= '0;
                end else begin
                    o_final_div_eff[DIV_W*g +: DIV_W] <= frac_fed ? i_final_div[DIV_W*g +: DIV_W]
                                                                 : i_int_div[DIV_W*g +: DIV_W];
                end
            end
            ckoc_outlane u_lane (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_en_grp0(en0_pin & i_grp0_map[g] | i_api_en0[g]),
                .i_en_grp1(en1_pin & i_grp1_map[g] | i_api_en1[g]),
                .i_run(i_run),
                .i_slow(i_slow_out[g]),
                .i_dis_mode(ckoc_dis_t'(i_dis_mode[2*g +: 2])),
                .i_clk_src(src_clk[g]),
                .o_pad(pad_w[g]),
                .o_pad_oe(oe_w[g]),
                .o_weak_pull(weak_w[g])
            );
            assign o_clk_pad[g] = pad_w[g];
            assign o_clk_pad_oe[g] = oe_w[g];
            assign o_clk_weak[g] = weak_w[g];
            // Status outputs are push-pull; address bit only on pin three
            if (g < NUM_GPIO) begin : g_gpo
                logic [2:0] fn;
                logic val;
                assign fn = i_gpio_fn[3*g +: 3];
                assign val = (fn == CKOC_FN_REF_LOSS) ? ref_loss_d :
                             (fn == CKOC_FN_IRQ) ? irq_d :
                             (fn == CKOC_FN_ADDR1 && g == ADDR_PIN) ? i_serial_out : 1'b0;
                assign gpo_d[g] = val ^ i_gpio_low[g];
                assign gpo_oe_d[g] = (fn == CKOC_FN_REF_LOSS) | (fn == CKOC_FN_IRQ) |
                                     (fn == CKOC_FN_ADDR1 && g == ADDR_PIN);
            end
        end
    endgenerate

    // Registered status, settings and general pin drive
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_gpio_out <= '0;
            o_gpio_oe <= '0;
            o_reuse_out <= '0;
            o_reference_loss <= 1'b0;
            o_interrupt_request_out <= 1'b0;
            o_ref_sel <= 1'b0;
            o_freq_offset <= FREQ_RST;
            o_fb_offset <= FREQ_RST;
            o_phase <= PHASE_RST;
            o_route <= '0;
            o_delay <= '0;
            o_frac_cfg <= '0;
            o_sticky <= CMD_RST;
        end else begin
            o_gpio_out <= gpo_d;
            o_gpio_oe <= gpo_oe_d;
            // Reused clock outputs carry reference loss (A) or the interrupt (B) when their clock pad is not driven
            o_reuse_out <= {~oe_w[REUSE_OUT_B] & irq_d,
                            ~oe_w[REUSE_OUT_A] & ref_loss_d};
            o_reference_loss <= ref_loss_d;
            o_interrupt_request_out <= irq_d;
            o_ref_sel <= ref_sel_q;
            o_freq_offset <= freq_q;
            o_fb_offset <= fb_q;
            o_phase <= phase_q;
            o_route <= route_q;
            o_delay <= delay_q;
            o_frac_cfg <= {i_frac_b_is_frac, i_frac_b_val, i_frac_a_is_frac, i_frac_a_val};
            o_sticky <= sticky_q;
        end
    end

    // Checks
    AST_REF_LOSS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_xtal_lost | i_osc_in_lost) |=> o_reference_loss)
        else $error("reference loss not reported");
    AST_STEP_UP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_q == CKOC_ST_UP) |=> freq_q == $past(freq_q) + $past(i_step_word))
        else $error("increment did not add step word");
    AST_STEP_DN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_q == CKOC_ST_DOWN) |=> freq_q == $past(freq_q) - $past(i_step_word))
        else $error("decrement did not subtract step word");
    AST_ONE_STEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (st_q == CKOC_ST_UP) |=> (st_q == CKOC_ST_HOLD) ##1 (st_q == CKOC_ST_IDLE))
        else $error("step not single");
    AST_STICKY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (sticky_q[0] && !i_sticky_clr[0]) |=> sticky_q[0])
        else $error("sticky dropped without clear");
    AST_REF_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_cmd_ref_sel |=> $stable(ref_sel_q))
        else $error("reference changed without command");
    AST_LOCKED: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_loop_lock_lost && st_q == CKOC_ST_IDLE) |=> st_q == CKOC_ST_IDLE)
        else $error("step while unlocked");
    AST_IRQ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!i_irq_and_mode && |(sticky_q & i_irq_mask)) |=> o_interrupt_request_out)
        else $error("interrupt missing");
    COV_UP: cover property (@(posedge i_clk) disable iff (i_sys_rst) st_q == CKOC_ST_UP);
    COV_DN: cover property (@(posedge i_clk) disable iff (i_sys_rst) st_q == CKOC_ST_DOWN);
    COV_IRQ: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_interrupt_request_out);
endmodule

// ---- src/ckoc_pkg.sv ----
// Package of constants and types for the clock output and general pin control block
package ckoc_pkg;
    localparam int NUM_OUT = 12;
    localparam int NUM_GPIO = 4;
    localparam int NUM_REUSE = 2;
    localparam int REUSE_OUT_A = 2;
    localparam int REUSE_OUT_B = 11;
    localparam int ADDR_PIN = 3;
    localparam int FREQ_W = 32;
    localparam int DELAY_W = 8;
    localparam int DIV_W = 16;
    localparam int PHASE_W = 16;
    // Values after reset
    localparam logic [FREQ_W-1:0] FREQ_RST = 32'h0000_0000;
    localparam logic [PHASE_W-1:0] PHASE_RST = 16'h0000;
    localparam logic [1:0] CMD_RST = 2'h0;
    // Crosspoint sources
    typedef enum logic [1:0] {
        CKOC_SRC_LOOP = 2'h0,
        CKOC_SRC_REF = 2'h1,
        CKOC_SRC_FRAC_A = 2'h2,
        CKOC_SRC_FRAC_B = 2'h3
    } ckoc_src_t;
    // Disabled output states
    typedef enum logic [1:0] {
        CKOC_DIS_HIGH = 2'h0,
        CKOC_DIS_LOW = 2'h1,
        CKOC_DIS_HIZ = 2'h2,
        CKOC_DIS_WEAK = 2'h3
    } ckoc_dis_t;
    // General pin functions
    typedef enum logic [2:0] {
        CKOC_FN_NONE = 3'h0,
        CKOC_FN_STEP_UP = 3'h1,
        CKOC_FN_STEP_DN = 3'h2,
        CKOC_FN_EN0 = 3'h3,
        CKOC_FN_EN1 = 3'h4,
        CKOC_FN_REF_LOSS = 3'h5,
        CKOC_FN_IRQ = 3'h6,
        CKOC_FN_ADDR1 = 3'h7
    } ckoc_fn_t;
    // One-hot states of the oscillator stepper
    typedef enum logic [3:0] {
        CKOC_ST_IDLE = 4'b0001,
        CKOC_ST_UP = 4'b0010,
        CKOC_ST_DOWN = 4'b0100,
        CKOC_ST_HOLD = 4'b1000
    } ckoc_state_t;
endpackage

// ---- src/ckoc_sync.sv ----
// Two-stage synchroniser with rising edge pulse for pin inputs
`timescale 1ns/1ps
module ckoc_sync
    import ckoc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Pin and results
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    // First stage is read only by the second stage
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end
    assign o_level = sync_q;
    // One pulse per assertion so a held pin steps once
    assign o_rise = sync_q & ~prev_q;
endmodule

// ---- src/ckoc_outlane.sv ----
// One output lane: enable OR, disabled state and pad controls
`timescale 1ns/1ps
module ckoc_outlane
    import ckoc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Controls
    input wire logic i_en_grp0,
    input wire logic i_en_grp1,
    input wire logic i_run,
    input wire logic i_slow,
    input wire ckoc_dis_t i_dis_mode,
    input wire logic i_clk_src,
    // Pad
    output logic o_pad,
    output logic o_pad_oe,
    output logic o_weak_pull
);
    logic en;
    logic weak_ok;
    logic pad_d;
    logic oe_d;
    // Either group enables the lane; nothing toggles during reset
    assign en = (i_en_grp0 | i_en_grp1) & i_run;
    // Weak pull only allowed on slow single-ended lanes, else plain high impedance
    assign weak_ok = (i_dis_mode == CKOC_DIS_WEAK) & i_slow;
    assign pad_d = en ? i_clk_src : (i_dis_mode == CKOC_DIS_HIGH);
    assign oe_d = en | (i_dis_mode == CKOC_DIS_HIGH) | (i_dis_mode == CKOC_DIS_LOW);
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pad <= 1'b0;
            o_pad_oe <= 1'b0;
            o_weak_pull <= 1'b0;
        end else begin
            o_pad <= pad_d;
            o_pad_oe <= oe_d;
            o_weak_pull <= ~en & weak_ok;
        end
    end
endmodule

// ---- test/ckoc_host.sv ----
// Host-side model that sends debounced step pulses on a general pin
`timescale 1ns/1ps
module ckoc_host (
    input wire logic i_clk,
    input wire logic i_go,
    output logic o_pin
);
    int cnt = 0;
    // One clean pulse per request, long enough to outlast the pin synchroniser
    always @(posedge i_clk) begin
        if (i_go) cnt <= 4;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    assign o_pin = (cnt > 0);
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the clock output and general pin control block
`timescale 1ns/1ps
module tb_top;
    import ckoc_pkg::*;
    logic i_clk = 0, i_sys_rst = 1, i_nvm_load = 0, go = 0, pin;
    logic i_loop_clk = 0, i_ref_clk = 0, i_frac_a_clk = 0, i_frac_b_clk = 0;
    logic i_frac_a_is_frac = 0, i_frac_b_is_frac = 0, i_fine_skew = 0, i_run = 0;
    logic i_cmd_ref_val = 0;
    // One command bit per host command; only one is raised at a time
    logic [6:0] cmd = 0;
    localparam int FUP = 0, FDN = 1, FBU = 2, FBD = 3, PAD = 4, PRT = 5, RSL = 6;
    wire i_cmd_freq_up = cmd[0], i_cmd_freq_dn = cmd[1], i_cmd_fb_up = cmd[2];
    wire i_cmd_fb_dn = cmd[3], i_cmd_phase_adv = cmd[4], i_cmd_phase_ret = cmd[5];
    wire i_cmd_ref_sel = cmd[6];
    logic i_loop_lock_lost = 0, i_xtal_lost = 0, i_osc_in_lost = 0, i_irq_and_mode = 0;
    logic i_serial_out = 0, o_reference_loss, o_interrupt_request_out, o_ref_sel;
    logic [1:0] i_irq_mask = 0, i_sticky_clr = 0, o_sticky;
    logic [2*NUM_OUT-1:0] i_nvm_route = 0, i_dis_mode = 0, o_route;
    logic [DELAY_W*NUM_OUT-1:0] i_nvm_delay = 0, o_delay;
    logic [DIV_W*NUM_OUT-1:0] i_int_div = 0, i_final_div = 0, o_final_div_eff;
    logic [DIV_W-1:0] i_frac_a_val = 0, i_frac_b_val = 0;
    logic [NUM_OUT-1:0] i_slow_out = 0, i_api_en0 = 0, i_api_en1 = 0;
    logic [NUM_OUT-1:0] i_grp0_map = 0, i_grp1_map = 0, o_clk_pad, o_clk_pad_oe, o_clk_weak;
    logic [3*NUM_GPIO-1:0] i_gpio_fn = 0;
    logic [NUM_GPIO-1:0] i_gpio_low = 0, i_gpio_driven = 0, i_gpio_in, o_gpio_out, o_gpio_oe;
    logic [NUM_REUSE-1:0] o_reuse_out;
    logic [FREQ_W-1:0] i_step_word = 0, o_freq_offset, o_fb_offset, exp_f = 0, exp_fb = 0;
    logic [PHASE_W-1:0] o_phase, exp_ph = 0;
    logic [2*DIV_W+1:0] o_frac_cfg;
    int n_mismatch = 0, n_compared = 0;

    ckoc_top ckoc_top_i (.*);
    ckoc_host ckoc_host_i (.i_clk(i_clk), .i_go(go), .o_pin(pin));
    assign i_gpio_in = {i_serial_out, 2'h0, pin};

    // Bench clock and two free-running source clocks for the crosspoint
    always #4 i_clk = ~i_clk;
    always #6 {i_loop_clk, i_frac_a_clk} = ~{i_loop_clk, i_frac_a_clk};

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // Commands must stay at least three cycles apart, so each pulse leaves a gap
    task automatic pulse(input int b);
        @(posedge i_clk) cmd <= 7'h1 << b;
        @(posedge i_clk) cmd <= 7'h0;
        repeat (5) @(posedge i_clk);
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog sized well above the expected run length
    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        summarize;
    end

    initial begin
        void'($urandom(32'he2af));
        repeat (8) @(posedge i_clk);
        chk({20'h0, o_clk_pad}, 0);
        i_sys_rst <= 0;
        i_run <= 1;
        for (int k = 0; k < 6; k++) begin
            i_step_word <= $urandom;
            @(posedge i_clk);
            if (k[0]) begin
                exp_f = exp_f - i_step_word;
                pulse(FDN);
            end else begin
                exp_f = exp_f + i_step_word;
                pulse(FUP);
            end
            chk(o_freq_offset, exp_f);
        end
        // Unlocked loop must ignore a step
        i_loop_lock_lost <= 1;
        pulse(FUP);
        chk(o_freq_offset, exp_f);
        i_loop_lock_lost <= 0;
        exp_fb = i_step_word;
        pulse(FBU);
        chk(o_fb_offset, exp_fb);
        exp_fb = exp_fb - i_step_word;
        pulse(FBD);
        chk(o_fb_offset, exp_fb);
        // Step pin on general pin zero, driven by the host model
        i_gpio_fn <= 12'h001;
        i_gpio_driven <= 4'h1;
        exp_f = exp_f + i_step_word;
        @(posedge i_clk) go <= 1;
        @(posedge i_clk) go <= 0;
        repeat (12) @(posedge i_clk);
        chk(o_freq_offset, exp_f);
        chk(o_fb_offset, exp_fb);
        // Phase: coarse moves four units, fine moves one
        for (int k = 0; k < 4; k++) begin
            i_fine_skew <= k[0];
            exp_ph = k[1] ? exp_ph - (k[0] ? 1 : 4) : exp_ph + (k[0] ? 1 : 4);
            if (k[1]) pulse(PRT);
            else pulse(PAD);
            chk({16'h0, o_phase}, {16'h0, exp_ph});
        end
        for (int v = 1; v >= 0; v--) begin
            i_cmd_ref_val <= v[0];
            pulse(RSL);
            i_cmd_ref_val <= ~v[0];
            repeat (5) @(posedge i_clk);
            chk_b(o_ref_sel, v[0]);
        end
        // Disabled lanes held high then low
        for (int m = 0; m < 2; m++) begin
            i_dis_mode <= {NUM_OUT{m[1:0]}};
            repeat (6) @(posedge i_clk);
            chk({8'h0, o_clk_pad_oe, o_clk_pad}, {8'h0, 12'hfff, m ? 12'h0 : 12'hfff});
        end
        i_dis_mode <= {NUM_OUT{2'h2}};
        for (int k = 0; k < 4; k++) begin
            i_api_en0 <= NUM_OUT'($urandom);
            i_api_en1 <= NUM_OUT'($urandom);
            repeat (6) @(posedge i_clk);
            chk({20'h0, o_clk_pad_oe}, {20'h0, i_api_en0 | i_api_en1});
        end
        // Weak pull only on slow lanes, then a pin-driven group over all lanes
        i_dis_mode <= {NUM_OUT{2'h3}};
        i_api_en0 <= '0;
        i_api_en1 <= '0;
        i_slow_out <= NUM_OUT'($urandom);
        repeat (6) @(posedge i_clk);
        chk({20'h0, o_clk_weak}, {20'h0, i_slow_out});
        i_gpio_fn <= 12'h003;
        i_grp0_map <= '1;
        // Driven low pin turns the group off; undriven it defaults to asserted
        for (int d = 0; d < 2; d++) begin
            i_gpio_driven <= d[0] ? 4'h0 : 4'h1;
            repeat (6) @(posedge i_clk);
            chk({20'h0, o_clk_pad_oe}, {20'h0, (d ? 12'hfff : 12'h000)});
        end
        i_grp0_map <= '0;
        // Status on pins: one inverted reference loss, two interrupt, three serial out
        i_gpio_fn <= 12'hfa8;
        i_serial_out <= 1;
        i_gpio_low <= 4'h2;
        i_irq_mask <= 2'h2;
        i_xtal_lost <= 1;
        repeat (6) @(posedge i_clk);
        chk_b(o_reference_loss, 1);
        chk({26'h0, o_gpio_oe[3:1], o_gpio_out[3:1]}, 32'h3e);
        chk({30'h0, o_reuse_out}, 32'h3);
        i_xtal_lost <= 0;
        repeat (6) @(posedge i_clk);
        chk_b(o_reference_loss, 0);
        chk_b(o_interrupt_request_out, 1);
        i_sticky_clr <= 2'h3;
        @(posedge i_clk) i_sticky_clr <= 2'h0;
        repeat (6) @(posedge i_clk);
        chk_b(o_interrupt_request_out, 0);
        chk({30'h0, o_sticky}, 32'h0);
        i_osc_in_lost <= 1;
        repeat (6) @(posedge i_clk);
        chk_b(o_reference_loss, 1);
        // Stored routing and delays on the load strobe; fractional then loop sources
        for (int m = 0; m < 2; m++) begin
            i_nvm_route <= {NUM_OUT{(m ? 2'h0 : 2'h2)}};
            i_nvm_delay <= {3{$urandom}};
            i_int_div <= {6{$urandom}};
            i_final_div <= {6{$urandom}};
            i_frac_a_val <= 16'($urandom);
            i_frac_a_is_frac <= m[0];
            i_nvm_load <= 1;
            @(posedge i_clk) i_nvm_load <= 0;
            repeat (4) @(posedge i_clk);
            chk({8'h0, o_route}, {8'h0, i_nvm_route});
            chk(o_delay[31:0], i_nvm_delay[31:0]);
            chk({16'h0, o_final_div_eff[15:0]},
                {16'h0, (m ? i_int_div[15:0] : i_final_div[15:0])});
            chk({15'h0, o_frac_cfg[16:0]}, {15'h0, i_frac_a_is_frac, i_frac_a_val});
        end
        // Hard reset in mid-run: lanes stop and the step offset returns to rest
        i_sys_rst <= 1;
        repeat (2) @(posedge i_clk);
        chk({20'h0, o_clk_pad}, 32'h0);
        chk(o_freq_offset, FREQ_RST);
        i_sys_rst <= 0;
        repeat (4) @(posedge i_clk);
        chk_b(o_reference_loss, 1);
        summarize;
    end
endmodule
